// *** inc/sffw_map.svh ***
// Bit positions, reset values and limits of the fast feedback word
`ifndef SFFW_MAP_SVH
`define SFFW_MAP_SVH
`define SFFW_WORD_OFFSET  4'h0
`define SFFW_WORD_RESET   32'h00000000
`define SFFW_BIT_SOL      31
`define SFFW_BIT_RDY      30
`define SFFW_BIT_PERR     29
`define SFFW_BIT_FAULT    28
`define SFFW_BIT_INPUT    27
`define SFFW_BIT_DN       26
`define SFFW_BIT_UP       25
`define SFFW_POS_MSB      24
`define SFFW_POS_W        25
`define SFFW_STEPS_W      26
`define SFFW_STEPS_MIN    26'h0000002
`define SFFW_ST13_MAX     26'h0002000
`define SFFW_MT21_MAX     26'h0200000
`define SFFW_MT25_MAX     26'h2000000
`define SFFW_ST13_MASK    25'h0001FFF
`define SFFW_MT21_MASK    25'h01FFFFF
`define SFFW_MT25_MASK    25'h1FFFFFF
`define SFFW_RED_W        4
`define SFFW_RED_RESET    4'h0
`endif

// *** inc/sffw_pkg.sv ***
// Types of the fast feedback word block
package sffw_pkg;
    typedef enum logic [1:0] {
        SFFW_ENC_ST13,
        SFFW_ENC_MT21,
        SFFW_ENC_MT25,
        SFFW_ENC_RSVD
    } sffw_enc_type;

    typedef enum logic [1:0] {
        SFFW_UNCONF,
        SFFW_RUN,
        SFFW_PERR
    } sffw_state_type;
endpackage : sffw_pkg

// *** inc/sffw_dir_if.sv ***
// Position samples to the direction detector and its status back
`timescale 1ns/1ps
`include "sffw_map.svh"
interface sffw_dir_if;
    logic                        sample;
    logic [`SFFW_POS_MSB:0]      position;
    logic [`SFFW_POS_MSB:0]      mask;
    logic                        up;
    logic                        down;
    modport src  (output sample, output position, output mask,
                  input up, input down);
    modport dirn (input sample, input position, input mask,
                  output up, output down);
endinterface : sffw_dir_if

// *** rtl/sffw_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module sffw_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : sffw_sync

// *** rtl/sffw_dir.sv ***
// Direction detector with wrap through zero
`timescale 1ns/1ps
`include "sffw_map.svh"
module sffw_dir (
    input  wire logic clock,
    input  wire logic rst_n,
    sffw_dir_if.dirn  dif
);
    logic [`SFFW_POS_MSB:0] prev;
    logic [`SFFW_POS_MSB:0] next_prev;
    logic                   have;
    logic                   next_have;
    logic                   up;
    logic                   next_up;
    logic                   down;
    logic                   next_down;
    logic [`SFFW_POS_MSB:0] diff;
    logic                   fwd;

    // Modular step within the encoder resolution
    assign diff = (dif.position - prev) & dif.mask;
    assign fwd  = (diff <= (dif.mask >> 1));

    // Direction holds until the position moves again
    always_comb begin
        next_prev = prev;
        next_have = have;
        next_up   = up;
        next_down = down;
        if (dif.sample) begin
            next_prev = dif.position & dif.mask;
            next_have = 1'b1;
            if (have && diff != '0) begin
                next_up   = fwd;
                next_down = !fwd;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '0;
            have <= 1'b0;
            up   <= 1'b0;
            down <= 1'b0;
        end else begin
            prev <= next_prev;
            have <= next_have;
            up   <= next_up;
            down <= next_down;
        end
    end

    assign dif.up   = up;
    assign dif.down = down;

    property p_dir_down;
        @(posedge clock) disable iff (!rst_n)
        dif.sample && have && diff != '0 && !fwd |=> down && !up;
    endproperty
    a_dir_down: assert property (p_dir_down)
        else $error("down status not set on falling position");

    property p_dir_up;
        @(posedge clock) disable iff (!rst_n)
        dif.sample && have && diff != '0 && fwd |=> up && !down;
    endproperty
    a_dir_up: assert property (p_dir_up)
        else $error("up status not set on rising position");
endmodule : sffw_dir

// *** rtl/sffw_top.sv ***
// Fast-mode feedback word of the absolute encoder input module
//
// Behaviour
// - bit 31 is zero without sign of life, else the toggle.
// - bit 30 carries the ready flag; feedback valid.
// - bit 29 carries the parameter error flag.
// - bit 28 carries one group fault: encoder errors or supply short.
// - bits 27, 26, 25 carry input, down and up status.
// - bits 0 to 24 carry the encoder position.
// - parameter error set when total steps out of range for type.
// - parameter error cleared when a valid parameter set arrives.
// - group fault on short, missing, wire break, mismatch, defect, parity.
// - group fault clears by itself once all causes are gone.
// - sign of life works only in isochronous mode.
// - sign of life inverts on each encoder value read in.
// - with sampling reduction, toggle only on real acquisitions.
// - input status bit follows the digital input level.
// - down status on position falling, wrap through zero included.
// - ready only with correct parameters and module active.
`timescale 1ns/1ps
`include "sffw_map.svh"
module sffw_top (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic                      cfg_strobe,
    input  wire logic [`SFFW_STEPS_W-1:0]  cfg_total_steps,
    input  wire logic [1:0]                cfg_encoder_type,
    input  wire logic                      cfg_iso_mode,
    input  wire logic                      cfg_sign_of_life,
    input  wire logic [`SFFW_RED_W-1:0]    cfg_reduction,
    input  wire logic                      module_active,
    input  wire logic                      iso_cycle,
    input  wire logic                      value_strobe,
    input  wire logic [`SFFW_POS_MSB:0]    value_position,
    input  wire logic                      frame_parity_error,
    input  wire logic                      encoder_missing,
    input  wire logic                      wire_break,
    input  wire logic                      encoder_mismatch,
    input  wire logic                      encoder_defective,
    input  wire logic                      supply_short,
    input  wire logic                      digital_input,
    output logic                           sample_request,
    output logic [31:0]                    feedback_word
);
    logic                           rst_meta;
    logic                           rst_n;
    logic [1:0]                     pins_sync;
    logic                           input_sync;
    logic                           short_sync;

    sffw_pkg::sffw_state_type       state;
    sffw_pkg::sffw_state_type       next_state;
    sffw_pkg::sffw_enc_type         enc;
    sffw_pkg::sffw_enc_type         next_enc;
    logic                           iso;
    logic                           next_iso;
    logic                           sol_on;
    logic                           next_sol_on;
    logic [`SFFW_RED_W-1:0]         red;
    logic [`SFFW_RED_W-1:0]         next_red;
    logic [`SFFW_STEPS_W-1:0]       steps_max;
    logic                           steps_bad;
    logic                           param_error;

    logic [`SFFW_RED_W-1:0]         red_cnt;
    logic [`SFFW_RED_W-1:0]         next_red_cnt;
    logic                           next_sample_request;
    logic                           sol_active;
    logic                           sol_bit;
    logic                           next_sol_bit;

    logic                           parity_fault;
    logic                           next_parity_fault;
    logic                           any_cause;
    logic                           group_fault;
    logic                           next_group_fault;

    logic [`SFFW_POS_MSB:0]         position;
    logic [`SFFW_POS_MSB:0]         next_position;
    logic [`SFFW_POS_MSB:0]         pos_mask;
    logic                           ready;
    logic [31:0]                    next_word;

    sffw_dir_if                     dif ();

    // Reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin levels into the clock domain
    sffw_sync #(.W(2)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   ({digital_input, supply_short}),
        .dout  (pins_sync)
    );
    assign input_sync = pins_sync[1];
    assign short_sync = pins_sync[0];

    // Step limit and resolution per encoder type
    always_comb begin
        case (sffw_pkg::sffw_enc_type'(cfg_encoder_type))
            sffw_pkg::SFFW_ENC_ST13: steps_max = `SFFW_ST13_MAX;
            sffw_pkg::SFFW_ENC_MT21: steps_max = `SFFW_MT21_MAX;
            sffw_pkg::SFFW_ENC_MT25: steps_max = `SFFW_MT25_MAX;
            default:                 steps_max = '0;
        endcase
        case (enc)
            sffw_pkg::SFFW_ENC_ST13: pos_mask = `SFFW_ST13_MASK;
            sffw_pkg::SFFW_ENC_MT21: pos_mask = `SFFW_MT21_MASK;
            default:                 pos_mask = `SFFW_MT25_MASK;
        endcase
    end

    // Total steps outside the permitted range
    assign steps_bad = (cfg_total_steps < `SFFW_STEPS_MIN)
                    || (cfg_total_steps > steps_max);

    // Parameter state: each new set is checked afresh
    always_comb begin
        next_state  = state;
        next_enc    = enc;
        next_iso    = iso;
        next_sol_on = sol_on;
        next_red    = red;
        if (cfg_strobe) begin
            next_enc    = sffw_pkg::sffw_enc_type'(cfg_encoder_type);
            next_iso    = cfg_iso_mode;
            next_sol_on = cfg_sign_of_life;
            next_red    = cfg_reduction;
            case (state)
                sffw_pkg::SFFW_UNCONF,
                sffw_pkg::SFFW_RUN,
                sffw_pkg::SFFW_PERR: begin
                    if (steps_bad) begin
                        next_state = sffw_pkg::SFFW_PERR;
                    end else begin
                        next_state = sffw_pkg::SFFW_RUN;
                    end
                end
                default: next_state = sffw_pkg::SFFW_UNCONF;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state  <= sffw_pkg::SFFW_UNCONF;
            enc    <= sffw_pkg::SFFW_ENC_MT25;
            iso    <= 1'b0;
            sol_on <= 1'b0;
            red    <= `SFFW_RED_RESET;
        end else begin
            state  <= next_state;
            enc    <= next_enc;
            iso    <= next_iso;
            sol_on <= next_sol_on;
            red    <= next_red;
        end
    end

    assign param_error = (state == sffw_pkg::SFFW_PERR);
    // Ready needs good parameters and an active module
    assign ready = (state == sffw_pkg::SFFW_RUN)
                && module_active;

    // Sign of life only in isochronous mode
    assign sol_active = iso && sol_on;

    // Reduced acquisition request and sign-of-life toggle
    always_comb begin
        next_red_cnt        = red_cnt;
        next_sample_request = 1'b0;
        next_sol_bit        = sol_bit;
        if (!iso) begin
            next_red_cnt = '0;
        end else if (iso_cycle) begin
            if (red_cnt == '0) begin
                next_sample_request = 1'b1;
                next_red_cnt        = red;
            end else begin
                next_red_cnt = red_cnt - 1'b1;
            end
        end
        if (!sol_active) begin
            next_sol_bit = 1'b0;
        end else if (value_strobe) begin
            next_sol_bit = !sol_bit;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            red_cnt        <= `SFFW_RED_RESET;
            sample_request <= 1'b0;
            sol_bit        <= 1'b0;
        end else begin
            red_cnt        <= next_red_cnt;
            sample_request <= next_sample_request;
            sol_bit        <= next_sol_bit;
        end
    end

    // Fault causes; parity fault holds until a clean frame
    assign any_cause = short_sync || encoder_missing || wire_break
                    || encoder_mismatch || encoder_defective
                    || parity_fault;

    always_comb begin
        next_parity_fault = parity_fault;
        next_position     = position;
        if (value_strobe) begin
            next_parity_fault = frame_parity_error;
            if (!frame_parity_error) begin
                next_position = value_position & pos_mask;
            end
        end
        next_group_fault = any_cause;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parity_fault <= 1'b0;
            group_fault  <= 1'b0;
            position     <= '0;
        end else begin
            parity_fault <= next_parity_fault;
            group_fault  <= next_group_fault;
            position     <= next_position;
        end
    end

    // Clean frames go to the direction detector
    assign dif.sample   = value_strobe && !frame_parity_error;
    assign dif.position = value_position;
    assign dif.mask     = pos_mask;

    sffw_dir u_dir (
        .clock (clock),
        .rst_n (rst_n),
        .dif   (dif)
    );

    // Assemble the feedback word
    always_comb begin
        next_word                     = `SFFW_WORD_RESET;
        next_word[`SFFW_BIT_SOL]      = sol_active && sol_bit;
        next_word[`SFFW_BIT_RDY]      = ready;
        next_word[`SFFW_BIT_PERR]     = param_error;
        next_word[`SFFW_BIT_FAULT]    = group_fault;
        next_word[`SFFW_BIT_INPUT]    = input_sync;
        next_word[`SFFW_BIT_DN]       = dif.down;
        next_word[`SFFW_BIT_UP]       = dif.up;
        next_word[`SFFW_POS_MSB:0]    = position;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            feedback_word <= `SFFW_WORD_RESET;
        end else begin
            feedback_word <= next_word;
        end
    end

    // Checks on the word and its causes
    property p_sol_zero;
        @(posedge clock) disable iff (!rst_n)
        !sol_active |=> !feedback_word[`SFFW_BIT_SOL];
    endproperty
    a_sol_zero: assert property (p_sol_zero)
        else $error("sign of life bit set while inactive");

    property p_sol_toggle;
        @(posedge clock) disable iff (!rst_n)
        sol_active && value_strobe ##1 sol_active
            |=> feedback_word[`SFFW_BIT_SOL] != $past(sol_bit, 2);
    endproperty
    a_sol_toggle: assert property (p_sol_toggle)
        else $error("sign of life did not toggle on new value");

    property p_sol_hold;
        @(posedge clock) disable iff (!rst_n)
        sol_active && !value_strobe |=> sol_bit == $past(sol_bit);
    endproperty
    a_sol_hold: assert property (p_sol_hold)
        else $error("sign of life toggled without acquisition");

    property p_ready;
        @(posedge clock) disable iff (!rst_n)
        feedback_word[`SFFW_BIT_RDY]
            |-> $past(state == sffw_pkg::SFFW_RUN && module_active);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready shown without valid operation");

    property p_perr_no_ready;
        @(posedge clock) disable iff (!rst_n)
        feedback_word[`SFFW_BIT_PERR] |-> !feedback_word[`SFFW_BIT_RDY];
    endproperty
    a_perr_no_ready: assert property (p_perr_no_ready)
        else $error("ready shown with parameter error");

    property p_perr_set;
        @(posedge clock) disable iff (!rst_n)
        cfg_strobe && steps_bad |=> ##1 feedback_word[`SFFW_BIT_PERR];
    endproperty
    a_perr_set: assert property (p_perr_set)
        else $error("bad step count not flagged");

    property p_perr_clear;
        @(posedge clock) disable iff (!rst_n)
        cfg_strobe && !steps_bad |=> ##1 !feedback_word[`SFFW_BIT_PERR];
    endproperty
    a_perr_clear: assert property (p_perr_clear)
        else $error("parameter error not cleared by good set");

    property p_fault_set;
        @(posedge clock) disable iff (!rst_n)
        any_cause |=> ##1 feedback_word[`SFFW_BIT_FAULT];
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("group fault missing for active cause");

    property p_fault_clear;
        @(posedge clock) disable iff (!rst_n)
        !any_cause |=> ##1 !feedback_word[`SFFW_BIT_FAULT];
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("group fault stuck after causes gone");

    property p_input;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> feedback_word[`SFFW_BIT_INPUT] == $past(input_sync);
    endproperty
    a_input: assert property (p_input)
        else $error("input status does not follow input");

    property p_pos;
        @(posedge clock) disable iff (!rst_n)
        value_strobe && !frame_parity_error
            |=> ##1 feedback_word[`SFFW_POS_MSB:0]
                    == ($past(value_position, 2) & $past(pos_mask, 2));
    endproperty
    a_pos: assert property (p_pos)
        else $error("position field wrong");

    property p_dir_word;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> feedback_word[`SFFW_BIT_UP] == $past(dif.up)
              && feedback_word[`SFFW_BIT_DN] == $past(dif.down);
    endproperty
    a_dir_word: assert property (p_dir_word)
        else $error("direction bits misplaced");

    // Main scenarios
    c_sol_toggle: cover property (@(posedge clock) disable iff (!rst_n)
        sol_active && value_strobe);
    c_perr: cover property (@(posedge clock) disable iff (!rst_n)
        cfg_strobe && steps_bad);
    c_fault: cover property (@(posedge clock) disable iff (!rst_n)
        feedback_word[`SFFW_BIT_FAULT]);
    c_down: cover property (@(posedge clock) disable iff (!rst_n)
        feedback_word[`SFFW_BIT_DN]);
endmodule : sffw_top

// *** verif/sffw_ctrl_model.sv ***
// Bus controller model: isochronous cycle source and feedback reader
`timescale 1ns/1ps
module sffw_ctrl_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [31:0] feedback_word,
    input  wire logic        sample_request,
    output logic             iso_cycle
);
    logic [31:0] read_word;
    int          requests = 0;

    initial iso_cycle = 1'h0;

    // Reads the input data once per bus cycle, counts acquisitions
    always @(posedge clock) begin
        if (iso_cycle && resetn) read_word <= feedback_word;
        if (sample_request === 1'h1) requests <= requests + 1;
    end

    // One bus cycle mark, a single clock wide
    task automatic pulse_iso();
        @(posedge clock);
        iso_cycle <= 1'h1;
        @(posedge clock);
        iso_cycle <= 1'h0;
    endtask : pulse_iso
endmodule : sffw_ctrl_model

// *** verif/tb.sv ***
// Self-checking bench of the fast feedback word block
`timescale 1ns/1ps
module tb;
    logic        clock, resetn, cfg_strobe, cfg_iso_mode, cfg_sign_of_life;
    logic [25:0] cfg_total_steps;
    logic [1:0]  cfg_encoder_type;
    logic [3:0]  cfg_reduction;
    logic        module_active, iso_cycle, value_strobe, frame_parity_error;
    logic [24:0] value_position;
    logic        encoder_missing, wire_break, encoder_mismatch;
    logic        encoder_defective, supply_short, digital_input;
    logic        sample_request;
    logic [31:0] feedback_word;
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [25:0] st [8] = '{26'h0000002, 26'h0000001, 26'h0002000,
        26'h0002001, 26'h0200000, 26'h0200001, 26'h2000000, 26'h0000010};
    logic [1:0]  ty [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};

    sffw_top u_dut (.clock, .resetn, .cfg_strobe, .cfg_total_steps,
        .cfg_encoder_type, .cfg_iso_mode, .cfg_sign_of_life, .cfg_reduction,
        .module_active, .iso_cycle, .value_strobe, .value_position,
        .frame_parity_error, .encoder_missing, .wire_break,
        .encoder_mismatch, .encoder_defective, .supply_short,
        .digital_input, .sample_request, .feedback_word);
    sffw_ctrl_model u_ctrl (.clock, .resetn, .feedback_word,
        .sample_request, .iso_cycle);

    // Clock source
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // Bounded wait for one word bit, then compare
    task automatic wait_bit(input int idx, input logic val, input string nm);
        int n;
        n = 0;
        while (feedback_word[idx] !== val && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(nm, {31'h0, val}, {31'h0, feedback_word[idx]});
    endtask : wait_bit

    // New parameter set; returns once the word has taken it
    task automatic set_cfg(input logic [25:0] s, input logic [1:0] t,
                           input logic iso, input logic sol,
                           input logic [3:0] red);
        @(posedge clock);
        cfg_strobe <= 1'h1;
        cfg_total_steps <= s;
        cfg_encoder_type <= t;
        cfg_iso_mode <= iso;
        cfg_sign_of_life <= sol;
        cfg_reduction <= red;
        @(posedge clock);
        cfg_strobe <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
    endtask : set_cfg

    // One encoder frame; returns once the word has taken it
    task automatic send_value(input logic [24:0] pos, input logic par);
        @(posedge clock);
        value_strobe <= 1'h1;
        value_position <= pos;
        frame_parity_error <= par;
        @(posedge clock);
        value_strobe <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
    endtask : send_value

    task automatic test_params();
        for (int i = 0; i < 8; i++) begin
            set_cfg(st[i], ty[i], 1'h0, 1'h0, 4'h0);
            check("param error", {31'h0, i[0]}, feedback_word[29]);
            check("ready", {31'h0, ~i[0]}, feedback_word[30]);
        end
        set_cfg(26'h2000000, 2'h2, 1'h0, 1'h0, 4'h0);
        @(posedge clock);
        module_active <= 1'h0;
        wait_bit(30, 1'h0, "ready idle");
        @(posedge clock);
        module_active <= 1'h1;
        wait_bit(30, 1'h1, "ready active");
        $display("test params done");
    endtask : test_params

    task automatic test_position();
        send_value(25'h0000064, 1'h0);
        check("position", 32'h64, feedback_word[24:0]);
        send_value(25'h00000C8, 1'h0);
        check("up/down", 32'h1, feedback_word[26:25]);
        send_value(25'h0000032, 1'h0);
        check("up/down", 32'h2, feedback_word[26:25]);
        send_value(25'h1FFFFF0, 1'h0);
        check("up/down", 32'h2, feedback_word[26:25]);
        send_value(25'h0000005, 1'h0);
        check("up/down", 32'h1, feedback_word[26:25]);
        send_value(25'h0000123, 1'h1);
        check("kept position", 32'h5, feedback_word[24:0]);
        check("fault", 32'h1, feedback_word[28]);
        send_value(25'h0000006, 1'h0);
        check("fault", 32'h0, feedback_word[28]);
        check("position", 32'h6, feedback_word[24:0]);
        $display("test position done");
    endtask : test_position

    task automatic test_faults();
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            {encoder_missing, wire_break, encoder_mismatch, encoder_defective,
             supply_short} <= 5'h01 << i;
            wait_bit(28, 1'h1, "fault set");
            @(posedge clock);
            {encoder_missing, wire_break, encoder_mismatch, encoder_defective,
             supply_short} <= 5'h00;
            wait_bit(28, 1'h0, "fault clear");
        end
        @(posedge clock);
        digital_input <= 1'h1;
        wait_bit(27, 1'h1, "input status");
        @(posedge clock);
        digital_input <= 1'h0;
        wait_bit(27, 1'h0, "input status");
        $display("test faults done");
    endtask : test_faults

    task automatic test_sign_of_life();
        logic s;
        int   n;
        set_cfg(26'h2000000, 2'h2, 1'h1, 1'h1, 4'h0);
        s = feedback_word[31];
        u_ctrl.pulse_iso();
        #1;
        check("sample request", 32'h1, sample_request);
        check("bus read", 32'h1, u_ctrl.read_word[30]);
        send_value(25'h0000010, 1'h0);
        check("sign of life", {31'h0, ~s}, feedback_word[31]);
        send_value(25'h0000011, 1'h0);
        check("sign of life", {31'h0, s}, feedback_word[31]);
        set_cfg(26'h2000000, 2'h2, 1'h1, 1'h1, 4'h2);
        s = feedback_word[31];
        n = u_ctrl.requests;
        repeat (3) begin
            u_ctrl.pulse_iso();
            #1;
            if (sample_request === 1'h1) send_value(25'h0000020, 1'h0);
        end
        repeat (2) @(posedge clock);
        check("requests", 32'h1, u_ctrl.requests - n);
        check("sign of life", {31'h0, ~s}, feedback_word[31]);
        set_cfg(26'h2000000, 2'h2, 1'h0, 1'h1, 4'h0);
        n = u_ctrl.requests;
        u_ctrl.pulse_iso();
        repeat (3) @(posedge clock);
        send_value(25'h0000021, 1'h0);
        check("requests", 32'h0, u_ctrl.requests - n);
        check("sign of life", 32'h0, feedback_word[31]);
        set_cfg(26'h2000000, 2'h2, 1'h1, 1'h0, 4'h0);
        send_value(25'h0000022, 1'h0);
        check("sign of life", 32'h0, feedback_word[31]);
        $display("test sign of life done");
    endtask : test_sign_of_life

    task automatic test_done();
        $display("checks %0d, num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {resetn, cfg_strobe, cfg_iso_mode, cfg_sign_of_life} = 4'h0;
        {cfg_total_steps, cfg_encoder_type, cfg_reduction} = 32'h0;
        {module_active, value_strobe, frame_parity_error} = 3'h0;
        value_position = 25'h0;
        {encoder_missing, wire_break, encoder_mismatch} = 3'h0;
        {encoder_defective, supply_short, digital_input} = 3'h0;
        repeat (3) @(posedge clock);
        resetn <= 1'h1;
        module_active <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check("reset word", 32'h0, feedback_word);
        $display("test reset done");
        test_params();
        test_position();
        test_faults();
        test_sign_of_life();
        test_done();
    end
endmodule : tb
